/* File: card_irq_pkg.sv */
// Package: register map, status bit layout and reset values for the card status/interrupt block
// Operation
// R1: The response time-out error flag sets when the response latency limit is exceeded and clears on a command register write.
// R2: The data CRC error flag sets on a CRC16 mismatch in the last data block and clears on a status register read.
// R3: The data time-out error flag sets when the data time-out from cycles and multiplier expires and clears on a status read.
// R4: The overrun flag sets when a received byte is lost unread and clears when a new data transfer command is issued.
// R5: The underrun flag sets when a byte is sent without valid data and clears when a new data transfer command is issued.
// R6: The receive-buffer-full flag reads 1 only while both the current and next receive DMA counters are zero.
// R7: The transmit-buffer-empty flag reads 1 only while both the current and next transmit DMA counters are zero.
// R8: Writing 1 to an interrupt enable bit enables that source, and writing 0 leaves it unchanged.
// R9: Writing 1 to an interrupt disable bit disables that source, and writing 0 leaves it unchanged.
// R10: Reading the mask register returns 1 for every enabled source and 0 for every disabled one.
// R11: Enable, disable and mask registers share the status bit layout of bits 0-7, 14-15, 16-22 and 30-31.
// R12: The command-sent flag sets when the last command has gone out and clears on a command register write.
// R13: The interrupt line is high while any status flag is set with its mask bit set, and all mask bits reset to 0.
package card_irq_pkg;

    // Register byte addresses
    localparam logic [31:0] ADDR_STATUS      = 32'hFFFA_8040;
    localparam logic [31:0] ADDR_ENABLE_SET  = 32'hFFFA_8044;
    localparam logic [31:0] ADDR_ENABLE_CLR  = 32'hFFFA_8048;
    localparam logic [31:0] ADDR_MASK        = 32'hFFFA_804C;

    // Status bit positions
    localparam int BIT_COMMAND_SENT     = 0;
    localparam int BIT_RX_WORD_READY    = 1;
    localparam int BIT_TX_WORD_TAKEN    = 2;
    localparam int BIT_BLOCK_DONE       = 3;
    localparam int BIT_XFER_ACTIVE      = 4;
    localparam int BIT_CARD_FREE        = 5;
    localparam int BIT_RX_COUNT_ZERO    = 6;
    localparam int BIT_TX_COUNT_ZERO    = 7;
    localparam int BIT_RX_DMA_FULL      = 14;
    localparam int BIT_TX_DMA_EMPTY     = 15;
    localparam int BIT_RESP_INDEX_ERR   = 16;
    localparam int BIT_RESP_DIR_ERR     = 17;
    localparam int BIT_RESP_CRC_ERR     = 18;
    localparam int BIT_RESP_ENDBIT_ERR  = 19;
    localparam int BIT_RESP_TIMEOUT_ERR = 20;
    localparam int BIT_DATA_CRC_ERR     = 21;
    localparam int BIT_DATA_TIMEOUT_ERR = 22;
    localparam int BIT_RX_OVERRUN       = 30;
    localparam int BIT_TX_UNDERRUN      = 31;

    // Implemented bits of the shared layout
    localparam logic [31:0] LAYOUT_MASK = 32'hC07F_C0FF;

    // Reset values
    localparam logic [31:0] MASK_RESET  = 32'h0000_0000;
    localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;

endpackage

/* File: card_status_irq.sv */
// Status flags, interrupt enable/disable/mask registers and interrupt line of the card host
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns

// One sticky flag; a set pulse beats a clear in the same cycle
module sticky_flag
    import card_irq_pkg::*;
#(
    parameter logic RESET_VALUE = 1'b0
)
(
    // Clock, reset, enable
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    // Set and clear events
    input  wire logic set_pulse,
    input  wire logic clear_pulse,
    // Flag state
    output logic      flag
);

    logic next_flag;

    // Clear first, then set, so an event landing on a clear is not lost
    always_comb
    begin
        next_flag = flag;
        if (clear_pulse)
            next_flag = 1'b0;
        if (set_pulse)
            next_flag = 1'b1;
    end

    // Flag register, frozen while clk_en is low
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            flag <= RESET_VALUE;
        else if (clk_en)
            flag <= next_flag;
    end

endmodule

module card_status_irq
    import card_irq_pkg::*;
#(
    parameter int COUNT_W = 16
)
(
    // Clock, reset, enable
    input  wire logic               mclk,
    input  wire logic               rst_b,
    input  wire logic               clk_en,
    // Register port
    input  wire logic [31:0]        reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_write,
    input  wire logic               reg_read,
    output logic      [31:0]        reg_rdata,
    // Command strobes from the command path
    input  wire logic               command_write,
    input  wire logic               data_xfer_command,
    // Flag-set pulses from command and data logic
    input  wire logic               command_done,
    input  wire logic               resp_latency_expired,
    input  wire logic               data_crc_mismatch,
    input  wire logic               data_timeout_expired,
    input  wire logic               rx_byte_lost,
    input  wire logic               tx_byte_starved,
    input  wire logic               resp_index_mismatch,
    input  wire logic               resp_dir_missing,
    input  wire logic               resp_crc_mismatch,
    input  wire logic               resp_endbit_missing,
    // Live levels from data path and DMA counters
    input  wire logic               rx_word_ready,
    input  wire logic               tx_word_taken,
    input  wire logic               block_done,
    input  wire logic               xfer_active,
    input  wire logic               card_free,
    input  wire logic               rx_count_zero,
    input  wire logic               tx_count_zero,
    input  wire logic [COUNT_W-1:0] rx_counter,
    input  wire logic [COUNT_W-1:0] rx_next_counter,
    input  wire logic [COUNT_W-1:0] tx_counter,
    input  wire logic [COUNT_W-1:0] tx_next_counter,
    // Interrupt
    output logic                    irq
);

    // Mask and read data registers
    logic [31:0] mask;
    logic [31:0] next_mask;
    logic [31:0] next_rdata;
    // Assembled status word
    logic [31:0] status;
    // Sticky flags, one flop each
    logic        command_sent;
    logic        resp_index_err;
    logic        resp_dir_err;
    logic        resp_crc_err;
    logic        resp_endbit_err;
    logic        resp_timeout_err;
    logic        data_crc_err;
    logic        data_timeout_err;
    logic        rx_overrun;
    logic        tx_underrun;
    // Decoded register strobes
    logic        status_read;
    logic        enable_set_write;
    logic        enable_clear_write;
    logic        cmd_wr;

    // Address decode; addresses compared whole, no byte lanes
    assign status_read        = reg_read && (reg_addr == ADDR_STATUS);
    assign enable_set_write   = reg_write && (reg_addr == ADDR_ENABLE_SET);
    assign enable_clear_write = reg_write && (reg_addr == ADDR_ENABLE_CLR);
    assign cmd_wr             = command_write;

    // Status word: sticky flags plus live levels
    always_comb
    begin
        // Sticky part
        status = 32'h0000_0000;
        status[BIT_COMMAND_SENT]     = command_sent;
        status[BIT_RESP_INDEX_ERR]   = resp_index_err;
        status[BIT_RESP_DIR_ERR]     = resp_dir_err;
        status[BIT_RESP_CRC_ERR]     = resp_crc_err;
        status[BIT_RESP_ENDBIT_ERR]  = resp_endbit_err;
        status[BIT_RESP_TIMEOUT_ERR] = resp_timeout_err;
        status[BIT_DATA_CRC_ERR]     = data_crc_err;
        status[BIT_DATA_TIMEOUT_ERR] = data_timeout_err;
        status[BIT_RX_OVERRUN]       = rx_overrun;
        status[BIT_TX_UNDERRUN]      = tx_underrun;
        // Live part; counter flags follow the counters as they stand
        status[BIT_RX_WORD_READY] = rx_word_ready;
        status[BIT_TX_WORD_TAKEN] = tx_word_taken;
        status[BIT_BLOCK_DONE]    = block_done;
        status[BIT_XFER_ACTIVE]   = xfer_active;
        status[BIT_CARD_FREE]     = card_free;
        status[BIT_RX_COUNT_ZERO] = rx_count_zero;
        status[BIT_TX_COUNT_ZERO] = tx_count_zero;
        status[BIT_RX_DMA_FULL]   = (rx_counter == '0) && (rx_next_counter == '0); // R6
        status[BIT_TX_DMA_EMPTY]  = (tx_counter == '0) && (tx_next_counter == '0); // R7
        status = status & LAYOUT_MASK; // R11
    end

    // Command group: all cleared by a command register write
    // Command sent
    sticky_flag
    #(
        .RESET_VALUE (FLAGS_RESET[BIT_COMMAND_SENT])
    )
    command_sent_flag
    (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .clk_en      (clk_en),
        .set_pulse   (command_done), // R12
        .clear_pulse (cmd_wr), // R12
        .flag        (command_sent)
    );

    // Response index error
    sticky_flag
    #(
        .RESET_VALUE (FLAGS_RESET[BIT_RESP_INDEX_ERR])
    )
    resp_index_flag
    (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .clk_en      (clk_en),
        .set_pulse   (resp_index_mismatch),
        .clear_pulse (cmd_wr),
        .flag        (resp_index_err)
    );

    // Response direction error
    sticky_flag
    #(
        .RESET_VALUE (FLAGS_RESET[BIT_RESP_DIR_ERR])
    )
    resp_dir_flag
    (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .clk_en      (clk_en),
        .set_pulse   (resp_dir_missing),
        .clear_pulse (cmd_wr),
        .flag        (resp_dir_err)
    );

    // Response CRC error
    sticky_flag
    #(
        .RESET_VALUE (FLAGS_RESET[BIT_RESP_CRC_ERR])
    )
    resp_crc_flag
    (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .clk_en      (clk_en),
        .set_pulse   (resp_crc_mismatch),
        .clear_pulse (cmd_wr),
        .flag        (resp_crc_err)
    );

    // Response end bit error
    sticky_flag
    #(
        .RESET_VALUE (FLAGS_RESET[BIT_RESP_ENDBIT_ERR])
    )
    resp_endbit_flag
    (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .clk_en      (clk_en),
        .set_pulse   (resp_endbit_missing),
        .clear_pulse (cmd_wr),
        .flag        (resp_endbit_err)
    );

    // Response time-out error
    sticky_flag
    #(
        .RESET_VALUE (FLAGS_RESET[BIT_RESP_TIMEOUT_ERR])
    )
    resp_timeout_flag
    (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .clk_en      (clk_en),
        .set_pulse   (resp_latency_expired), // R1
        .clear_pulse (cmd_wr), // R1
        .flag        (resp_timeout_err)
    );

    // Data group: cleared by a status read, which still returns the old value
    // Data CRC error
    sticky_flag
    #(
        .RESET_VALUE (FLAGS_RESET[BIT_DATA_CRC_ERR])
    )
    data_crc_flag
    (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .clk_en      (clk_en),
        .set_pulse   (data_crc_mismatch), // R2
        .clear_pulse (status_read), // R2
        .flag        (data_crc_err)
    );

    // Data time-out error
    sticky_flag
    #(
        .RESET_VALUE (FLAGS_RESET[BIT_DATA_TIMEOUT_ERR])
    )
    data_timeout_flag
    (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .clk_en      (clk_en),
        .set_pulse   (data_timeout_expired), // R3
        .clear_pulse (status_read), // R3
        .flag        (data_timeout_err)
    );

    // Byte loss group: cleared by a new data transfer command
    // Receive overrun
    sticky_flag
    #(
        .RESET_VALUE (FLAGS_RESET[BIT_RX_OVERRUN])
    )
    rx_overrun_flag
    (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .clk_en      (clk_en),
        .set_pulse   (rx_byte_lost), // R4
        .clear_pulse (data_xfer_command), // R4
        .flag        (rx_overrun)
    );

    // Transmit underrun
    sticky_flag
    #(
        .RESET_VALUE (FLAGS_RESET[BIT_TX_UNDERRUN])
    )
    tx_underrun_flag
    (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .clk_en      (clk_en),
        .set_pulse   (tx_byte_starved), // R5
        .clear_pulse (data_xfer_command), // R5
        .flag        (tx_underrun)
    );

    // Mask: set then clear; a bit written in both stays disabled
    always_comb
    begin
        next_mask = mask;
        if (enable_set_write)
            next_mask = next_mask | (reg_wdata & LAYOUT_MASK); // R8 R11
        if (enable_clear_write)
            next_mask = next_mask & ~reg_wdata; // R9
    end

    // Read mux; write-only and unmapped addresses read zero
    always_comb
    begin
        next_rdata = reg_rdata;
        if (reg_read)
        begin
            case (reg_addr)
                ADDR_STATUS: next_rdata = status;
                ADDR_MASK:   next_rdata = mask; // R10
                default:     next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Mask register, frozen while clk_en is low
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            mask <= MASK_RESET; // R13
        else if (clk_en)
            mask <= next_mask;
    end

    // Read data register; keeps its word until the next read
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= 32'h0000_0000;
        else if (clk_en)
            reg_rdata <= next_rdata;
    end

    // Level interrupt from unmasked status, live bits included
    // Live bits raise it with no event, so keep them masked unless wanted
    assign irq = |(status & mask); // R13

endmodule

/* File: card_status_irq_sva.sv */
// Checker: readback and flag timing of the card status block
`timescale 1ns/1ns
module card_status_irq_sva
    import card_irq_pkg::*;
#(parameter int COUNT_W = 16)
(
    // Clock, reset, enable
    input wire logic               mclk,
    input wire logic               rst_b,
    input wire logic               clk_en,
    // Register port
    input wire logic               reg_read,
    input wire logic [31:0]        reg_addr,
    input wire logic [31:0]        reg_rdata,
    // Interrupt
    input wire logic               irq,
    // Strobes and pulses
    input wire logic               command_write,
    input wire logic               data_xfer_command,
    input wire logic               command_done,
    input wire logic               resp_latency_expired,
    input wire logic               data_crc_mismatch,
    input wire logic               rx_byte_lost,
    input wire logic               tx_byte_starved,
    // Counters
    input wire logic [COUNT_W-1:0] rx_counter,
    input wire logic [COUNT_W-1:0] rx_next_counter,
    input wire logic [COUNT_W-1:0] tx_counter,
    input wire logic [COUNT_W-1:0] tx_next_counter
);
    // Status read taken this cycle
    logic st;
    assign st = clk_en && reg_read && reg_addr == ADDR_STATUS;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_irq_reset_quiet: assert property ($rose(rst_b) |-> !irq) else $error("irq high after reset");
    a_rx_full_live: assert property (st |=> reg_rdata[14] == ($past(rx_counter) == 0 && $past(rx_next_counter) == 0))
        else $error("rx full bit wrong");
    a_tx_empty_live: assert property (st |=> reg_rdata[15] == ($past(tx_counter) == 0 && $past(tx_next_counter) == 0))
        else $error("tx empty bit wrong");
    a_enable_reads_zero: assert property (clk_en && reg_read && reg_addr == ADDR_ENABLE_SET |=> reg_rdata == 0)
        else $error("write-only register read nonzero");
    a_mask_layout_only: assert property (clk_en && reg_read && reg_addr == ADDR_MASK |=> (reg_rdata & ~LAYOUT_MASK) == 0)
        else $error("mask bit outside layout");
    a_overrun_sets: assert property (clk_en && rx_byte_lost ##1 !data_xfer_command ##1 st |=> reg_rdata[30])
        else $error("overrun not set");
    a_crc_read_clears: assert property (st && !data_crc_mismatch ##1 !data_crc_mismatch ##1 st |=> !reg_rdata[21])
        else $error("crc flag survived read");
    a_cmd_write_clears: assert property (clk_en && command_write && !resp_latency_expired && !command_done
        ##1 !resp_latency_expired && !command_done ##1 st |=> !reg_rdata[20] && !reg_rdata[0])
        else $error("command flags survived");
    a_underrun_clears: assert property (clk_en && data_xfer_command && !tx_byte_starved ##1 !tx_byte_starved ##1 st
        |=> !reg_rdata[31]) else $error("underrun survived");
endmodule
bind card_status_irq card_status_irq_sva
#(
    .COUNT_W (COUNT_W)
)
card_status_irq_sva_inst
(
    .mclk                 (mclk),
    .rst_b                (rst_b),
    .clk_en               (clk_en),
    .reg_read             (reg_read),
    .reg_addr             (reg_addr),
    .reg_rdata            (reg_rdata),
    .irq                  (irq),
    .command_write        (command_write),
    .data_xfer_command    (data_xfer_command),
    .command_done         (command_done),
    .resp_latency_expired (resp_latency_expired),
    .data_crc_mismatch    (data_crc_mismatch),
    .rx_byte_lost         (rx_byte_lost),
    .tx_byte_starved      (tx_byte_starved),
    .rx_counter           (rx_counter),
    .rx_next_counter      (rx_next_counter),
    .tx_counter           (tx_counter),
    .tx_next_counter      (tx_next_counter)
);

/* File: tb_card_status_irq.sv */
// Testbench: mask registers, sticky flags, live bits and interrupt line
`timescale 1ns/1ns
module tb_card_status_irq;
    import card_irq_pkg::*;
    logic mclk = 0, rst_b = 0, clk_en = 1, reg_write = 0, reg_read = 0, cw = 0, dx = 0, rd_seen = 0, irq;
    logic [31:0] reg_addr = 0, reg_wdata = 0, reg_rdata, m, d;
    logic [9:0] ev = 0;
    logic [6:0] lv = 0, r;
    logic [15:0] rc = 1, rn = 1, tc = 1, tn = 1;
    logic [31:0] exp_q[$];
    int seed = 32'h8995, mismatches = 0, cmp_count = 0;
    card_status_irq card_status_irq_inst (.mclk, .rst_b, .clk_en, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .irq, .command_write(cw), .data_xfer_command(dx), .command_done(ev[0]),
        .resp_latency_expired(ev[1]), .data_crc_mismatch(ev[2]), .data_timeout_expired(ev[3]),
        .rx_byte_lost(ev[4]), .tx_byte_starved(ev[5]), .resp_index_mismatch(ev[6]), .resp_dir_missing(ev[7]),
        .resp_crc_mismatch(ev[8]), .resp_endbit_missing(ev[9]), .rx_word_ready(lv[0]), .tx_word_taken(lv[1]),
        .block_done(lv[2]), .xfer_active(lv[3]), .card_free(lv[4]), .rx_count_zero(lv[5]), .tx_count_zero(lv[6]),
        .rx_counter(rc), .rx_next_counter(rn), .tx_counter(tc), .tx_next_counter(tn));
    // Free-running clock
    initial
    begin
        forever #4 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One bus cycle; a read notes its expected word
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_write <= w;
        reg_read <= !w;
        reg_addr <= a;
        reg_wdata <= v;
        if (!w)
            exp_q.push_back(v);
        @(posedge mclk);
        reg_write <= 0;
        reg_read <= 0;
    endtask
    task automatic pls(input logic [9:0] e, input logic c, input logic x);
        @(posedge mclk);
        ev <= e;
        cw <= c;
        dx <= x;
        @(posedge mclk);
        ev <= 0;
        cw <= 0;
        dx <= 0;
    endtask
    task automatic conclude;
        if (exp_q.size() != 0)
            mismatches++;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Read data stands one cycle after the taken read; compare mid-cycle
    always @(posedge mclk) rd_seen <= reg_read && clk_en;
    always @(negedge mclk)
        if (rd_seen && exp_q.size() > 0)
            chk(reg_rdata, exp_q.pop_front());
    // Hang guard
    initial
    begin
        #100000;
        mismatches++;
        conclude;
    end
    initial
    begin
        repeat (3) @(posedge mclk);
        rst_b <= 1;
        bus(0, ADDR_MASK, MASK_RESET);
        @(negedge mclk) chk({31'h0, irq}, 0);
        d = $random(seed);
        m = d & LAYOUT_MASK;
        bus(1, ADDR_ENABLE_SET, d);
        bus(0, ADDR_MASK, m);
        d = $random(seed);
        m = m & ~d;
        bus(1, ADDR_ENABLE_CLR, d);
        bus(1, ADDR_ENABLE_SET, 0);
        bus(1, ADDR_ENABLE_CLR, 0);
        bus(0, ADDR_MASK, m);
        bus(0, ADDR_ENABLE_SET, 0);
        bus(1, ADDR_ENABLE_CLR, 32'hFFFF_FFFF);
        pls(10'h3FF, 0, 0);
        bus(0, ADDR_STATUS, 32'hC07F_0001);
        bus(0, ADDR_STATUS, 32'hC01F_0001);
        pls(0, 1, 0);
        bus(0, ADDR_STATUS, 32'hC000_0000);
        bus(1, ADDR_ENABLE_SET, 32'h4000_0000);
        @(negedge mclk) chk({31'h0, irq}, 1);
        bus(1, ADDR_ENABLE_CLR, 32'h4000_0000);
        @(negedge mclk) chk({31'h0, irq}, 0);
        bus(1, ADDR_ENABLE_SET, 32'h8000_0000);
        @(negedge mclk) chk({31'h0, irq}, 1);
        pls(0, 0, 1);
        @(negedge mclk) chk({31'h0, irq}, 0);
        bus(0, ADDR_STATUS, 0);
        // Strobes and pulses with clk_en low must leave all state alone
        clk_en <= 0;
        bus(1, ADDR_ENABLE_SET, 32'h0000_0001);
        pls(10'h3FF, 1, 1);
        clk_en <= 1;
        bus(0, ADDR_MASK, 32'h8000_0000);
        bus(0, ADDR_STATUS, 0);
        // Counter zero combinations with random live bits
        for (int i = 0; i < 4; i++)
        begin
            d = $random(seed);
            r = d[6:0];
            @(posedge mclk);
            lv <= r;
            {rc, rn, tc, tn} <= {{15'h0, i[0]}, {15'h0, i[1]}, {15'h0, i[0]}, {15'h0, i[1]}};
            bus(0, ADDR_STATUS, {16'h0, i == 0, i == 0, 6'h0, r, 1'b0});
        end
        bus(0, 32'hFFFA_8050, 0);
        repeat (2) @(posedge mclk);
        conclude;
    end
endmodule
